/* File: hw/hbs_pkg.sv */
package hbs_pkg;
    // Six-level strap readings as presented by the analog sense front end.
    localparam logic [2:0] LVL_WEAK_PD = 3'h0;
    localparam logic [2:0] LVL_WEAK_PU = 3'h1;
    localparam logic [2:0] LVL_MED_PD = 3'h2;
    localparam logic [2:0] LVL_MED_PU = 3'h3;
    localparam logic [2:0] LVL_STRONG_PD = 3'h4;
    localparam logic [2:0] LVL_STRONG_PU = 3'h5;
    // Port counts selected by each level.
    localparam logic [2:0] CNT_0 = 3'h0;
    localparam logic [2:0] CNT_1 = 3'h1;
    localparam logic [2:0] CNT_2 = 3'h2;
    localparam logic [2:0] CNT_3 = 3'h3;
    localparam logic [2:0] CNT_4 = 3'h4;
    localparam logic [2:0] CNT_6 = 3'h6;
    // Interface-mode strap level that selects the target profile.
    localparam logic [2:0] PROFILE_TARGET_LVL = LVL_WEAK_PU;
    // Flash probe addresses and signature.
    localparam logic [15:0] SIG_ADDR = 16'hfffa;
    localparam logic [15:0] EXEC_ADDR = 16'h0000;
    localparam logic [31:0] SIG_WORD = 32'h32444655;
    // Configuration register offsets.
    localparam logic [7:0] REG_CFG_DONE = 8'hff;
    localparam logic [7:0] REG_GPIO_DIR = 8'h10;
    localparam logic [7:0] REG_GPIO_OUT = 8'h11;
    localparam logic [7:0] REG_GPIO_PEN = 8'h12;
    localparam logic [7:0] REG_GPIO_PSEL = 8'h13;
    localparam logic [7:0] REG_GPIO_IN = 8'h14;
    localparam logic [7:0] REG_STRAPS = 8'h15;
    localparam logic [7:0] REG_STAGE = 8'h16;
    // Boot stages.
    typedef enum logic [2:0] {
        HBS_STANDBY = 3'h0,
        HBS_PROBE = 3'h1,
        HBS_DEFLOAD = 3'h2,
        HBS_STRAP = 3'h3,
        HBS_HOSTCFG = 3'h4,
        HBS_MERGE = 3'h5,
        HBS_RUN = 3'h6
    } hbs_stage_e;
endpackage

/* File: hw/hbs_sequencer.sv */
`timescale 1ns/100ps
// Function
// [R1] Fixed-port strap level decodes to 0,1,2,3,4 or 6 non-removable ports.
// [R2] Charge-port strap level decodes the same way into charging ports.
// [R3] Each GPIO is input with optional pull, or output driving low or high.
// [R4] GPIO registers are writable at runtime from sideband or hub controller.
// [R5] Reset low holds standby: everything quiet, pins released, clock request off.
// [R6] Reset high runs the hub boot stages.
// [R7] Standby discards state, defaults all registers, disables downstream ports.
// [R8] After reset release: wait lock, default configuration, then probe flash. The code probes flash first and does the default load after it.
// [R9] Check flash signature at 0xFFFA; valid means execute external at 0x0000.
// [R10] Without SPI strap, skip flash and go to default load.
// [R11] Flash port supports single or dual data and clock modes 0 and 3.
// [R12] Attached flash holds at least 1 Mbit and runs at 60 MHz.
// [R13] Default load takes ROM defaults then overrides them with strap values.
// [R14] Strap stage latches straps; target profile with both pull-ups enters host config.
// [R15] Host configuration waits forever, with no timeout.
// [R16] A write to register 0xFF ends host configuration.
// [R17] Weak pull-up on interface-mode strap selects the sideband target profile.
// [R18] After host configuration the merge stage forms the final configuration.
// [R19] Each strap is a 3-bit code sampled once at boot and held.
module hbs_sequencer #(
    parameter int NGPIO = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pll_locked,
    input wire logic spi_mode_strap,
    input wire logic [2:0] fixed_port_strap,
    input wire logic [2:0] charge_port_strap,
    input wire logic [2:0] smbus_target_profile,
    input wire logic sideband_data_pin,
    input wire logic sideband_clock_pin,
    input wire logic flash_dual,
    input wire logic flash_mode3,
    output logic flash_req,
    output logic [15:0] flash_addr,
    input wire logic flash_ack,
    input wire logic [31:0] flash_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_from_usb,
    output logic [7:0] reg_rdata,
    output logic [2:0] stage,
    output logic ext_exec,
    output logic [15:0] exec_addr,
    output logic flash_dual_en,
    output logic flash_cpol,
    output logic [2:0] fixed_port_count,
    output logic [2:0] charge_port_count,
    output logic host_cfg_en,
    output logic cfg_done,
    output logic ports_en,
    output logic pll_run,
    input wire logic [NGPIO-1:0] gpio_in,
    output logic [NGPIO-1:0] gpio_out,
    output logic [NGPIO-1:0] gpio_oe,
    output logic [NGPIO-1:0] gpio_pull_en,
    output logic [NGPIO-1:0] gpio_pull_up
);

    ////////////////////////////////////////////////////////////////////////////
    // Level decode shared by both port-count straps.
    function automatic logic [2:0] lvl_to_cnt(input logic [2:0] lvl);
        logic [2:0] c;
        c = hbs_pkg::CNT_0;
        case (lvl)
            hbs_pkg::LVL_WEAK_PD: c = hbs_pkg::CNT_0;
            hbs_pkg::LVL_WEAK_PU: c = hbs_pkg::CNT_1;
            hbs_pkg::LVL_MED_PD: c = hbs_pkg::CNT_2;
            hbs_pkg::LVL_MED_PU: c = hbs_pkg::CNT_3;
            hbs_pkg::LVL_STRONG_PD: c = hbs_pkg::CNT_4;
            hbs_pkg::LVL_STRONG_PU: c = hbs_pkg::CNT_6;
            default: c = hbs_pkg::CNT_0;
        endcase
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when stages two and three agree.
    localparam int NSYNC = NGPIO + 3;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, sv_q, sv_d, raw;
    assign raw = {pll_locked, sideband_clock_pin, sideband_data_pin, gpio_in};

    // Stable value updates only when the last two stages agree, filtering single glitches.
    always_comb begin
        sv_d = sv_q;
        for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                sv_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sv_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sv_q <= sv_d;
        end
    end

    logic lock_s, sbc_s, sbd_s;
    logic [NGPIO-1:0] gin_s;
    assign lock_s = sv_q[NGPIO+2];
    assign sbc_s = sv_q[NGPIO+1];
    assign sbd_s = sv_q[NGPIO];
    assign gin_s = sv_q[NGPIO-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Boot stage sequencer and configuration state.
    hbs_pkg::hbs_stage_e st_q, st_d;
    logic freq_q, freq_d, ext_q, ext_d;
    logic [2:0] fcnt_q, fcnt_d, ccnt_q, ccnt_d, prof_q, prof_d;
    logic dual_q, dual_d, cpol_q, cpol_d, done_q, done_d, done_wr;
    logic run_q, hcfg_q, hcfg_d;
    logic [15:0] addr_q, addr_d;
    logic [NGPIO-1:0] pe_q, pe_d;
    logic [NGPIO-1:0] dir_q, dir_d, out_q, out_d, pen_q, pen_d, psel_q, psel_d;
    logic [7:0] rd_q, rd_d;

    // The trigger register is write-only and only meaningful during host config.
    assign done_wr = reg_wr && (reg_addr == hbs_pkg::REG_CFG_DONE); // [R16]

    // Stages advance on synchronised pin state; straps are sampled in one stage only.
    always_comb begin
        st_d = st_q;
        freq_d = freq_q;
        ext_d = ext_q;
        fcnt_d = fcnt_q;
        ccnt_d = ccnt_q;
        prof_d = prof_q;
        dual_d = dual_q;
        cpol_d = cpol_q;
        done_d = done_q;
        case (st_q)
            hbs_pkg::HBS_STANDBY: st_d = hbs_pkg::HBS_PROBE; // [R6]
            hbs_pkg::HBS_PROBE: begin
                if (lock_s) begin // [R8]
                    if (!spi_mode_strap) begin
                        st_d = hbs_pkg::HBS_DEFLOAD; // [R10]
                    end else if (!freq_q) begin
                        freq_d = 1'b1;
                        dual_d = flash_dual; // [R11]
                        cpol_d = flash_mode3; // [R11]
                    end else if (flash_ack) begin
                        freq_d = 1'b0;
                        ext_d = (flash_data == hbs_pkg::SIG_WORD); // [R9]
                        st_d = hbs_pkg::HBS_DEFLOAD; // [R9]
                    end
                end
            end
            hbs_pkg::HBS_DEFLOAD: begin
                // ROM defaults first, strap overrides replace them afterwards.
                fcnt_d = hbs_pkg::CNT_0; // [R13]
                ccnt_d = hbs_pkg::CNT_0;
                st_d = hbs_pkg::HBS_STRAP;
            end
            hbs_pkg::HBS_STRAP: begin
                fcnt_d = lvl_to_cnt(fixed_port_strap); // [R1] [R19]
                ccnt_d = lvl_to_cnt(charge_port_strap); // [R2] [R19]
                prof_d = smbus_target_profile; // [R14]
                if (smbus_target_profile == hbs_pkg::PROFILE_TARGET_LVL && sbd_s && sbc_s) begin
                    st_d = hbs_pkg::HBS_HOSTCFG; // [R14] [R17]
                end else begin
                    st_d = hbs_pkg::HBS_MERGE; // [R14]
                end
            end
            hbs_pkg::HBS_HOSTCFG: begin
                // No timeout: only the trigger write leaves this stage.
                if (done_wr) begin // [R15]
                    st_d = hbs_pkg::HBS_MERGE; // [R16]
                end
            end
            hbs_pkg::HBS_MERGE: begin
                done_d = 1'b1; // [R18]
                st_d = hbs_pkg::HBS_RUN;
            end
            hbs_pkg::HBS_RUN: st_d = hbs_pkg::HBS_RUN;
            default: st_d = hbs_pkg::HBS_STANDBY;
        endcase
    end

    // GPIO registers accept writes from either path in host config or run; readback of state.
    always_comb begin
        dir_d = dir_q;
        out_d = out_q;
        pen_d = pen_q;
        psel_d = psel_q;
        rd_d = rd_q;
        if (reg_wr && (st_q == hbs_pkg::HBS_RUN || st_q == hbs_pkg::HBS_HOSTCFG)) begin // [R4]
            case (reg_addr)
                hbs_pkg::REG_GPIO_DIR: dir_d = reg_wdata[NGPIO-1:0]; // [R3]
                hbs_pkg::REG_GPIO_OUT: out_d = reg_wdata[NGPIO-1:0]; // [R3]
                hbs_pkg::REG_GPIO_PEN: pen_d = reg_wdata[NGPIO-1:0]; // [R3]
                hbs_pkg::REG_GPIO_PSEL: psel_d = reg_wdata[NGPIO-1:0]; // [R3]
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                hbs_pkg::REG_GPIO_DIR: rd_d = 8'(dir_q);
                hbs_pkg::REG_GPIO_OUT: rd_d = 8'(out_q);
                hbs_pkg::REG_GPIO_PEN: rd_d = 8'(pen_q);
                hbs_pkg::REG_GPIO_PSEL: rd_d = 8'(psel_q);
                hbs_pkg::REG_GPIO_IN: rd_d = 8'(gin_s);
                hbs_pkg::REG_STRAPS: rd_d = {2'h0, ccnt_q, fcnt_q};
                hbs_pkg::REG_STAGE: rd_d = {2'h0, prof_q, st_q}; // [R14]
                default: rd_d = 8'h00;
            endcase
        end
    end

    // Asynchronous reset puts every register at its default: this is standby.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= hbs_pkg::HBS_STANDBY; // [R5] [R7]
            freq_q <= 1'b0;
            ext_q <= 1'b0;
            fcnt_q <= hbs_pkg::CNT_0;
            ccnt_q <= hbs_pkg::CNT_0;
            prof_q <= hbs_pkg::LVL_WEAK_PD;
            dual_q <= 1'b0;
            cpol_q <= 1'b0;
            done_q <= 1'b0;
            dir_q <= '0;
            out_q <= '0;
            pen_q <= '0;
            psel_q <= '0;
            rd_q <= 8'h00;
            run_q <= 1'b0;
            hcfg_q <= 1'b0;
            addr_q <= hbs_pkg::EXEC_ADDR;
            pe_q <= '0;
        end else begin
            st_q <= st_d;
            freq_q <= freq_d;
            ext_q <= ext_d;
            fcnt_q <= fcnt_d;
            ccnt_q <= ccnt_d;
            prof_q <= prof_d;
            dual_q <= dual_d;
            cpol_q <= cpol_d;
            done_q <= done_d;
            dir_q <= dir_d;
            out_q <= out_d;
            pen_q <= pen_d;
            psel_q <= psel_d;
            rd_q <= rd_d;
            run_q <= 1'b1; // [R5]
            hcfg_q <= hcfg_d;
            addr_q <= addr_d;
            pe_q <= pe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs load next-state values; pulls act on inputs only, never against a driver.
    assign pe_d = pen_d & ~dir_d; // [R3]
    assign addr_d = freq_d ? hbs_pkg::SIG_ADDR : hbs_pkg::EXEC_ADDR; // [R9]
    assign hcfg_d = (st_d == hbs_pkg::HBS_HOSTCFG); // [R15]

    assign flash_req = freq_q;
    assign flash_addr = addr_q;
    assign reg_rdata = rd_q;
    assign stage = st_q;
    assign ext_exec = ext_q;
    assign exec_addr = hbs_pkg::EXEC_ADDR;
    assign flash_dual_en = dual_q;
    assign flash_cpol = cpol_q;
    assign fixed_port_count = fcnt_q;
    assign charge_port_count = ccnt_q;
    assign host_cfg_en = hcfg_q;
    assign cfg_done = done_q;
    assign ports_en = done_q; // [R7]
    assign pll_run = run_q;
    assign gpio_out = out_q;
    assign gpio_oe = dir_q; // [R3]
    assign gpio_pull_en = pe_q;
    assign gpio_pull_up = psel_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_strap_target;
        st_q == hbs_pkg::HBS_STRAP && smbus_target_profile == hbs_pkg::PROFILE_TARGET_LVL
            && sbd_s && sbc_s;
    endsequence

    a_reset_standby: assert property (@(posedge clk) !rst_n |-> st_q == hbs_pkg::HBS_STANDBY)
        else $error("not in standby under reset"); // [R5]
    a_boot_probe: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_STANDBY |=> st_q == hbs_pkg::HBS_PROBE)
        else $error("probe not entered"); // [R8]
    a_no_spi_skip: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_PROBE && lock_s && !spi_mode_strap |=> st_q == hbs_pkg::HBS_DEFLOAD
            && !ext_q)
        else $error("flash not skipped"); // [R10]
    a_sig_check: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_PROBE && freq_q && flash_ack
            |=> ext_q == ($past(flash_data) == hbs_pkg::SIG_WORD))
        else $error("signature result wrong"); // [R9]
    a_fixed_decode: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_STRAP && fixed_port_strap == hbs_pkg::LVL_STRONG_PU
            |=> fcnt_q == hbs_pkg::CNT_6)
        else $error("fixed port decode wrong"); // [R1]
    a_charge_decode: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_STRAP && charge_port_strap == hbs_pkg::LVL_MED_PD
            |=> ccnt_q == hbs_pkg::CNT_2)
        else $error("charge port decode wrong"); // [R2]
    a_host_entry: assert property (@(posedge clk) disable iff (!rst_n)
        s_strap_target |=> st_q == hbs_pkg::HBS_HOSTCFG)
        else $error("host config not entered"); // [R14]
    a_host_hold: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_HOSTCFG && !done_wr |=> st_q == hbs_pkg::HBS_HOSTCFG)
        else $error("host config left early"); // [R15]
    a_done_exit: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_HOSTCFG && done_wr |=> st_q == hbs_pkg::HBS_MERGE ##1 cfg_done)
        else $error("trigger write ignored"); // [R16]
    a_strap_held: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_RUN |=> $stable(fcnt_q) && $stable(ccnt_q))
        else $error("strap code changed"); // [R19]
    a_gpio_dir: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_RUN && reg_wr && reg_addr == hbs_pkg::REG_GPIO_DIR
            |=> gpio_oe == $past(reg_wdata[NGPIO-1:0]))
        else $error("gpio direction not written"); // [R4]
    a_merge_run: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == hbs_pkg::HBS_MERGE |=> st_q == hbs_pkg::HBS_RUN && ports_en)
        else $error("merge did not finish"); // [R18]
endmodule

/* File: test/hbs_flash_model.sv */
`timescale 1ns/100ps
// Boot flash as seen by the probe: answers each request once, after dly cycles.
module hbs_flash_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flash_req,
    input wire logic [15:0] flash_addr,
    input wire logic sig_ok,
    input wire logic [3:0] dly,
    output logic flash_ack,
    output logic [31:0] flash_data
);
    logic [3:0] cnt_q;
    logic done_q;
    // Outside an answer the data toggles each cycle, so a stale word matches the last answer only on alternate cycles.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            flash_ack <= 1'b0;
            flash_data <= 32'h0;
        end else begin
            flash_ack <= 1'b0;
            flash_data <= ~flash_data;
            if (!flash_req) begin
                cnt_q <= 4'h0;
                done_q <= 1'b0;
            end else if (!done_q && cnt_q == dly) begin
                flash_ack <= 1'b1;
                done_q <= 1'b1;
                // A full-size part holds the signature word at the probe address.
                flash_data <= (sig_ok && flash_addr == hbs_pkg::SIG_ADDR) ?
                    hbs_pkg::SIG_WORD : ~hbs_pkg::SIG_WORD;
            end else if (!done_q) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

/* File: test/tb_hub_boot_strap_sequencer.sv */
`timescale 1ns/100ps
module tb_hub_boot_strap_sequencer;
    logic clk = 1'b0, rst_n = 1'b1, pll_locked = 1'b0, spi_mode_strap = 1'b0;
    logic sideband_data_pin = 1'b0, sideband_clock_pin = 1'b0, sig_ok = 1'b0;
    logic flash_dual = 1'b0, flash_mode3 = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_from_usb = 1'b0;
    logic [2:0] fixed_port_strap = 3'h0, charge_port_strap = 3'h0, smbus_target_profile = 3'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, gpio_in = 8'h00;
    logic [3:0] dly = 4'h0;
    logic flash_ack, flash_req, ext_exec, flash_dual_en, flash_cpol;
    logic host_cfg_en, cfg_done, ports_en, pll_run;
    logic [31:0] flash_data;
    logic [15:0] flash_addr, exec_addr;
    logic [7:0] reg_rdata, gpio_out, gpio_oe, gpio_pull_en, gpio_pull_up;
    logic [2:0] stage, fixed_port_count, charge_port_count;
    int error_cnt = 0;
    int n_compared = 0;

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    hbs_sequencer #(.NGPIO(8)) i_hbs_sequencer (
        .clk, .rst_n, .pll_locked, .spi_mode_strap, .fixed_port_strap, .charge_port_strap,
        .smbus_target_profile, .sideband_data_pin, .sideband_clock_pin, .flash_dual,
        .flash_mode3, .flash_req, .flash_addr, .flash_ack, .flash_data, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_from_usb, .reg_rdata, .stage, .ext_exec, .exec_addr,
        .flash_dual_en, .flash_cpol, .fixed_port_count, .charge_port_count, .host_cfg_en,
        .cfg_done, .ports_en, .pll_run, .gpio_in, .gpio_out, .gpio_oe, .gpio_pull_en,
        .gpio_pull_up
    );

    hbs_flash_model i_hbs_flash_model (
        .clk, .rst_n, .flash_req, .flash_addr, .sig_ok, .dly, .flash_ack, .flash_data
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Bounded wait for a stage; running out of cycles ends the run.
    task automatic wait_stage(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (stage !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (stage !== s) begin
            chk(stage, s);
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic usb);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_from_usb = usb;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Read data lands a cycle after the strobe and then stands.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask

    // Reset with new straps; the lock comes late so the probe must wait for it.
    task automatic boot(input logic spi, input logic [2:0] prof, input logic sda, input logic scl);
        @(negedge clk);
        rst_n = 1'b0;
        pll_locked = 1'b0;
        spi_mode_strap = spi;
        smbus_target_profile = prof;
        sideband_data_pin = sda;
        sideband_clock_pin = scl;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        pll_locked = 1'b1;
    endtask

    task automatic t_straps();
        logic [2:0] cnt [6];
        cnt = '{hbs_pkg::CNT_0, hbs_pkg::CNT_1, hbs_pkg::CNT_2, hbs_pkg::CNT_3,
            hbs_pkg::CNT_4, hbs_pkg::CNT_6};
        for (int lv = 0; lv < 6; lv++) begin
            fixed_port_strap = 3'(lv);
            charge_port_strap = 3'(5 - lv);
            boot(1'b0, hbs_pkg::LVL_WEAK_PD, 1'b1, 1'b1);
            wait_stage(hbs_pkg::HBS_DEFLOAD, 20);
            wait_stage(hbs_pkg::HBS_STRAP, 2);
            @(negedge clk);
            chk(stage, hbs_pkg::HBS_MERGE);
            wait_stage(hbs_pkg::HBS_RUN, 2);
            chk(fixed_port_count, cnt[lv]);
            chk(charge_port_count, cnt[5 - lv]);
            chk({ext_exec, cfg_done, ports_en, pll_run}, 4'h7);
            fixed_port_strap = 3'(5 - lv);
            repeat (4) @(negedge clk);
            chk(fixed_port_count, cnt[lv]);
        end
        $display("straps test done");
    endtask

    // Every data width and clock mode, valid and bad signatures, prompt and slow answers.
    task automatic t_flash();
        int n;
        for (int i = 0; i < 4; i++) begin
            flash_dual = i[0];
            flash_mode3 = i[1];
            sig_ok = (i != 2);
            dly = 4'(i * 5);
            boot(1'b1, hbs_pkg::LVL_WEAK_PD, 1'b0, 1'b0);
            n = 0;
            while (flash_req !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
            end
            if (flash_req !== 1'b1) begin
                chk(flash_req, 1'b1);
                report_and_stop();
            end
            chk(flash_addr, hbs_pkg::SIG_ADDR);
            wait_stage(hbs_pkg::HBS_DEFLOAD, 40);
            chk({flash_req, ext_exec}, {1'b0, sig_ok});
            chk(exec_addr, hbs_pkg::EXEC_ADDR);
            chk({flash_dual_en, flash_cpol}, {flash_dual, flash_mode3});
        end
        $display("flash test done");
    endtask

    task automatic t_host_cfg();
        boot(1'b0, hbs_pkg::PROFILE_TARGET_LVL, 1'b1, 1'b1);
        wait_stage(hbs_pkg::HBS_HOSTCFG, 20);
        repeat (300) @(negedge clk);
        chk(stage, hbs_pkg::HBS_HOSTCFG);
        chk({host_cfg_en, cfg_done, ports_en}, 3'h4);
        wr(hbs_pkg::REG_GPIO_DIR, 8'h0f, 1'b1);
        chk(gpio_oe, 8'h0f);
        wr(hbs_pkg::REG_CFG_DONE, 8'h00, 1'b0);
        wait_stage(hbs_pkg::HBS_MERGE, 2);
        wait_stage(hbs_pkg::HBS_RUN, 2);
        chk({host_cfg_en, cfg_done, ports_en}, 3'h3);
        // One pull-up missing, or another profile, must bypass host configuration.
        for (int i = 0; i < 3; i++) begin
            boot(1'b0, (i == 2) ? hbs_pkg::LVL_MED_PD : hbs_pkg::PROFILE_TARGET_LVL,
                i != 0, i != 1);
            wait_stage(hbs_pkg::HBS_STRAP, 20);
            @(negedge clk);
            chk(stage, hbs_pkg::HBS_MERGE);
        end
        $display("host config test done");
    endtask

    task automatic t_gpio();
        wait_stage(hbs_pkg::HBS_RUN, 4);
        wr(hbs_pkg::REG_GPIO_DIR, 8'h0f, 1'b0);
        wr(hbs_pkg::REG_GPIO_OUT, 8'h05, 1'b1);
        wr(hbs_pkg::REG_GPIO_PEN, 8'hff, 1'b0);
        wr(hbs_pkg::REG_GPIO_PSEL, 8'h30, 1'b1);
        chk({gpio_oe, gpio_out}, 16'h0f05);
        chk({gpio_pull_en, gpio_pull_up}, 16'hf030);
        gpio_in = 8'ha5;
        repeat (5) @(negedge clk);
        rd(hbs_pkg::REG_GPIO_IN, 8'ha5);
        rd(hbs_pkg::REG_GPIO_PSEL, 8'h30);
        rd(hbs_pkg::REG_STAGE, {2'h0, hbs_pkg::LVL_MED_PD, hbs_pkg::HBS_RUN});
        rd(8'h40, 8'h00);
        rd(hbs_pkg::REG_CFG_DONE, 8'h00);
        $display("gpio test done");
    endtask

    // Reset in mid-run drops everything and a fresh boot starts from defaults.
    task automatic t_standby();
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        chk({stage, pll_run, ports_en, cfg_done, flash_req}, 7'h00);
        chk({gpio_oe, gpio_pull_en, gpio_out}, 24'h000000);
        boot(1'b0, hbs_pkg::LVL_WEAK_PD, 1'b1, 1'b1);
        wait_stage(hbs_pkg::HBS_RUN, 20);
        chk(gpio_oe, 8'h00);
        $display("standby test done");
    endtask

    // Reset falls on an edge of its own, so every asynchronous reset branch really runs.
    initial begin
        @(negedge clk);
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        t_straps();
        t_flash();
        t_host_cfg();
        t_gpio();
        t_standby();
        report_and_stop();
    end
endmodule
